/* File: logic/dsle_core.sv */
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
// Summary of operation
// - Control word bit 0 picks user or master; words 1-16 hold the password.
// - Erase-unit takes a block, bit 1 picks enhanced erase, aborts on mismatch.
// - Freeze-lock sets frozen; later lock-changing commands are aborted.
// - Frozen clears only on power-on or hardware reset.
// - Freeze-lock while frozen completes normally and stays frozen.
// - While frozen, set, unlock, disable, erase-prepare and erase-unit abort.
// - Set-password bit 0 picks user/master, bit 8 level, word 17 revision.
// - User password at high level: lock at next hardware reset, user or master unlocks.
// - User password at maximum level: master kept but never unlocks.
// - Master password set loads revision code, lock and level untouched.
// - Master unlock compares master only at high level, rejects at maximum.
// - User unlock compares supplied password with stored user password.
// - Attempt counter starts at five, drops on each failed unlock while locked and not frozen.
// - At zero attempts, unlock and erase-unit abort until reset.
// - Unlock while unlocked leaves the attempt counter unchanged.
// - Disable-password unlocks on a match of the chosen password, master kept.
// - Master unlock is re-enabled only by setting a new high-level user password or by power-on reset.
module dsle_core
  import dsle_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hwResetPin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dsle_pkg::APB_AW-1:0] paddr,
  input wire logic [dsle_pkg::APB_DW-1:0] pwdata,
  output logic [dsle_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic frozenOut,
  output logic lockedOut,
  output logic eraseStart,
  output logic eraseEnhanced
);
  import dsle_pkg::*;

  function automatic logic pwEqual(input logic [PW_BITS-1:0] a, input logic [PW_BITS-1:0] b);
    return a == b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Hardware reset pin synchroniser
  logic hwSync1_r;
  logic hwSync2_r;
  logic hwPrev_r;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hwSync1_r <= 1'b0;
      hwSync2_r <= 1'b0;
      hwPrev_r <= 1'b0;
    end else begin
      hwSync1_r <= hwResetPin;
      hwSync2_r <= hwSync1_r;
      hwPrev_r <= hwSync2_r;
    end
  end
  wire logic hwRst = hwSync2_r & ~hwPrev_r;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire logic apbAccess = psel & penable;
  wire logic apbWr = apbAccess & pwrite;
  wire logic hitCmd = paddr == OFS_CMD;
  wire logic hitData = paddr == OFS_DATA;
  wire logic hitStat = paddr == OFS_STAT;
  wire logic hitRev = paddr == OFS_REV;
  wire logic mapped = hitCmd | hitData | hitStat | hitRev;
  assign pready = 1'b1;
  assign pslverr = apbAccess & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Command state
  dsle_state_e state_r;
  dsle_state_e state_nxt;
  logic [7:0] opcode_r;
  logic [7:0] wordIdx_r;
  logic [WORD_W-1:0] ctrlWord_r;
  logic [WORD_W-1:0] revIn_r;
  logic [PW_BITS-1:0] pwIn_r;
  logic [PW_BITS-1:0] userPw_r;
  logic [PW_BITS-1:0] masterPw_r;
  logic [WORD_W-1:0] masterRev_r;
  logic [ATT_W-1:0] attempts_r;
  logic frozen_r;
  logic locked_r;
  logic lockEn_r;
  logic levelMax_r;
  logic prepared_r;
  logic done_r;
  logic aborted_r;

  wire logic idle = state_r == ST_IDLE;
  wire logic cmdWr = apbWr & hitCmd & idle;
  wire logic dataWr = apbWr & hitData & (state_r == ST_RECV);
  wire logic [7:0] cmdOp = pwdata[7:0];
  wire logic noDataOp = (cmdOp == OP_ERASE_PREP) | (cmdOp == OP_FREEZE);
  wire logic lastWord = dataWr & (wordIdx_r == WORD_LAST);
  wire logic isPwWord = (wordIdx_r >= WORD_PW_FIRST) & (wordIdx_r <= WORD_PW_LAST);
  wire logic evalNow = state_r == ST_EVAL;
  wire logic [7:0] wordIdx_nxt = cmdWr ? WORD_CTRL : (dataWr ? wordIdx_r + 8'h01 : wordIdx_r);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (cmdWr) begin
          state_nxt = noDataOp ? ST_EVAL : ST_RECV;
        end
      end
      ST_RECV: begin
        if (lastWord) begin
          state_nxt = ST_EVAL;
        end
      end
      ST_EVAL: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data block capture
  always_ff @(posedge mclk) begin
    if (sys_rst || hwRst) begin
      state_r <= ST_IDLE;
      wordIdx_r <= WORD_CTRL;
    end else begin
      state_r <= state_nxt;
      wordIdx_r <= wordIdx_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      opcode_r <= 8'h00;
      ctrlWord_r <= 16'h0000;
      revIn_r <= 16'h0000;
      pwIn_r <= '0;
    end else begin
      if (cmdWr) begin
        opcode_r <= cmdOp;
      end
      if (dataWr && wordIdx_r == WORD_CTRL) begin
        ctrlWord_r <= pwdata[WORD_W-1:0];
      end
      if (dataWr && isPwWord) begin
        pwIn_r <= {pwIn_r[PW_BITS-WORD_W-1:0], pwdata[WORD_W-1:0]};
      end
      if (dataWr && wordIdx_r == WORD_REV) begin
        revIn_r <= pwdata[WORD_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command evaluation; reserved words and bits never steer it
  wire logic idMaster = ctrlWord_r[CW_ID_BIT];
  wire logic userMatch = pwEqual(pwIn_r, userPw_r);
  wire logic masterMatch = pwEqual(pwIn_r, masterPw_r);
  wire logic masterOk = masterMatch & ~levelMax_r;
  wire logic selMatch = idMaster ? masterOk : userMatch;
  wire logic noAttempts = attempts_r == ATTEMPTS_NONE;
  wire logic isSet = opcode_r == OP_SET_PW;
  wire logic isUnlock = opcode_r == OP_UNLOCK;
  wire logic isPrep = opcode_r == OP_ERASE_PREP;
  wire logic isErase = opcode_r == OP_ERASE_UNIT;
  wire logic isFreeze = opcode_r == OP_FREEZE;
  wire logic isDisable = opcode_r == OP_DISABLE_PW;
  wire logic knownOp = isSet | isUnlock | isPrep | isErase | isFreeze | isDisable;
  wire logic frozenBlock = frozen_r & ~isFreeze;
  wire logic eraseBad = isErase & (noAttempts | ~prepared_r | ~selMatch);
  wire logic unlockBad = isUnlock & (noAttempts | ~selMatch);
  wire logic setBad = isSet & locked_r;
  wire logic disableBad = isDisable & ~selMatch;
  wire logic rejectCmd = ~knownOp | frozenBlock | eraseBad | unlockBad | setBad | disableBad;
  wire logic evalOk = evalNow & ~rejectCmd;
  wire logic failCount = evalNow & isUnlock & ~frozen_r & ~noAttempts & ~selMatch & locked_r;
  wire logic unlockNow = evalOk & (isUnlock | isDisable | isErase);

  ////////////////////////////////////////////////////////////////////////////
  // Security state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      frozen_r <= 1'b0;
      attempts_r <= ATTEMPTS_INIT;
      locked_r <= 1'b0;
    end else if (hwRst) begin
      frozen_r <= 1'b0;
      attempts_r <= ATTEMPTS_INIT;
      locked_r <= lockEn_r;
    end else begin
      if (evalOk && isFreeze) begin
        frozen_r <= 1'b1;
      end
      if (failCount) begin
        attempts_r <= attempts_r - 3'h1;
      end
      if (unlockNow) begin
        locked_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      userPw_r <= '0;
      masterPw_r <= '0;
      masterRev_r <= 16'h0000;
      lockEn_r <= 1'b0;
      levelMax_r <= 1'b0;
    end else if (evalOk && isSet && idMaster) begin
      masterPw_r <= pwIn_r;
      masterRev_r <= revIn_r;
    end else if (evalOk && isSet) begin
      userPw_r <= pwIn_r;
      lockEn_r <= 1'b1;
      levelMax_r <= ctrlWord_r[CW_LEVEL_BIT];
    end else if (evalOk && (isDisable || isErase)) begin
      lockEn_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || hwRst) begin
      prepared_r <= 1'b0;
      done_r <= 1'b0;
      aborted_r <= 1'b0;
      eraseStart <= 1'b0;
      eraseEnhanced <= 1'b0;
    end else begin
      eraseStart <= evalOk & isErase;
      if (evalOk && isErase) begin
        eraseEnhanced <= ctrlWord_r[CW_ERASE_BIT];
      end
      if (evalNow) begin
        prepared_r <= evalOk & isPrep;
        done_r <= 1'b1;
        aborted_r <= rejectCmd;
      end else if (cmdWr) begin
        done_r <= 1'b0;
        aborted_r <= 1'b0;
      end
    end
  end

  assign frozenOut = frozen_r;
  assign lockedOut = locked_r;

  ////////////////////////////////////////////////////////////////////////////
  // Register read
  dsle_status_s status;
  assign status = '{lastOpcode: opcode_r, attempts: attempts_r, erasePrepared: prepared_r,
                    levelMax: levelMax_r, lockEnabled: lockEn_r, locked: locked_r, frozen: frozen_r,
                    aborted: aborted_r, done: done_r, busy: ~idle};
  wire logic [APB_DW-1:0] statWord = {{(APB_DW-STAT_W){1'b0}}, status};
  wire logic [APB_DW-1:0] revWord = {{(APB_DW-WORD_W){1'b0}}, masterRev_r};
  wire logic [APB_DW-1:0] cmdWord = {24'h000000, opcode_r};
  wire logic [APB_DW-1:0] rdMux = hitStat ? statWord : (hitRev ? revWord : (hitCmd ? cmdWord : 32'h00000000));

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  frozen_sticks_a: assert property (frozen_r && !hwRst |=> frozen_r)
    else $error("frozen cleared without reset");
  frozen_blocks_a: assert property (evalNow && frozen_r && !hwRst
    && (isSet || isUnlock || isDisable || isPrep || isErase) |=> aborted_r && done_r)
    else $error("command accepted while frozen");
  freeze_again_a: assert property (evalNow && isFreeze && frozen_r && !hwRst |=> !aborted_r && frozen_r)
    else $error("freeze while frozen failed");
  freeze_sets_a: assert property (evalNow && isFreeze |=> frozen_r || $past(hwRst))
    else $error("freeze lock did not freeze");
  attempt_drop_a: assert property (failCount && !hwRst |=> attempts_r == $past(attempts_r) - 3'h1)
    else $error("attempt counter not decremented");
  unlocked_keep_a: assert property (evalNow && isUnlock && !locked_r && !hwRst |=> $stable(attempts_r))
    else $error("unlock while unlocked changed counter");
  zero_rejects_a: assert property (evalNow && noAttempts && (isUnlock || isErase) && !hwRst |=> aborted_r)
    else $error("unlock or erase accepted at zero attempts");
  master_max_a: assert property (evalNow && isUnlock && idMaster && levelMax_r && !hwRst |=> aborted_r)
    else $error("master unlock accepted at maximum level");
  erase_prep_a: assert property (eraseStart |-> $past(prepared_r, 2) && !$past(frozen_r, 2))
    else $error("erase started without prepare");
  master_keep_a: assert property (evalNow && isSet && idMaster && !hwRst
    |=> $stable(lockEn_r) && $stable(levelMax_r))
    else $error("master set changed lock or level");

  ctrl_capture_a: assert property (dataWr && wordIdx_r == WORD_CTRL
    |=> ctrlWord_r == $past(pwdata[WORD_W-1:0]))
    else $error("control word not captured");
  rev_capture_a: assert property (dataWr && wordIdx_r == WORD_REV
    |=> revIn_r == $past(pwdata[WORD_W-1:0]))
    else $error("revision word not captured");
  erase_bad_pw_a: assert property (evalNow && isErase && !selMatch && !hwRst
    |=> aborted_r)
    else $error("erase accepted with wrong password");
  erase_mode_a: assert property (eraseStart
    |-> eraseEnhanced == $past(ctrlWord_r[CW_ERASE_BIT]))
    else $error("erase mode does not follow control word");
  frozen_no_erase_a: assert property (frozen_r
    |-> !eraseStart)
    else $error("erase started while frozen");
  zero_sticks_a: assert property (noAttempts && !hwRst
    |=> noAttempts)
    else $error("attempt counter left zero without reset");
  lock_on_reset_a: assert property (hwRst
    |=> locked_r == $past(lockEn_r))
    else $error("lock state not loaded at hardware reset");
  disable_master_a: assert property (evalNow && isDisable
    |=> $stable(masterPw_r))
    else $error("disable changed master password");
  disable_unlock_a: assert property (evalNow && isDisable && selMatch && !frozen_r && !hwRst
    |=> !locked_r)
    else $error("disable with matching password did not unlock");
  user_unlock_a: assert property (evalNow && isUnlock && !idMaster && userMatch && !frozen_r
    && !noAttempts && !hwRst |=> !locked_r)
    else $error("user unlock with matching password failed");
  user_reject_a: assert property (evalNow && isUnlock && !idMaster && !userMatch && !hwRst
    |=> aborted_r)
    else $error("user unlock accepted with wrong password");
  master_unlock_a: assert property (evalNow && isUnlock && idMaster && !levelMax_r && masterMatch
    && !frozen_r && !noAttempts && !hwRst |=> !locked_r)
    else $error("master unlock at high level failed");
  freeze_done_a: assert property (evalNow && isFreeze && !hwRst
    |=> frozen_r && !aborted_r)
    else $error("freeze lock did not complete normally");
  eval_done_a: assert property (evalNow && !hwRst
    |=> done_r && idle)
    else $error("command did not complete");

endmodule // dsle_core

/* File: logic/dsle_pkg.sv */
package dsle_pkg;

  // APB register map
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam logic [APB_AW-1:0] OFS_CMD = 8'h00;
  localparam logic [APB_AW-1:0] OFS_DATA = 8'h04;
  localparam logic [APB_AW-1:0] OFS_STAT = 8'h08;
  localparam logic [APB_AW-1:0] OFS_REV = 8'h0C;

  // Security command opcodes
  localparam logic [7:0] OP_SET_PW = 8'hF1;
  localparam logic [7:0] OP_UNLOCK = 8'hF2;
  localparam logic [7:0] OP_ERASE_PREP = 8'hF3;
  localparam logic [7:0] OP_ERASE_UNIT = 8'hF4;
  localparam logic [7:0] OP_FREEZE = 8'hF5;
  localparam logic [7:0] OP_DISABLE_PW = 8'hF6;

  // Data block layout, 16-bit words
  localparam int WORD_W = 16;
  localparam int PW_BITS = 256;
  localparam logic [7:0] WORD_CTRL = 8'h00;
  localparam logic [7:0] WORD_PW_FIRST = 8'h01;
  localparam logic [7:0] WORD_PW_LAST = 8'h10;
  localparam logic [7:0] WORD_REV = 8'h11;
  localparam logic [7:0] WORD_LAST = 8'hFF;
  localparam int CW_ID_BIT = 0;
  localparam int CW_ERASE_BIT = 1;
  localparam int CW_LEVEL_BIT = 8;

  // Unlock attempt counter
  localparam int ATT_W = 3;
  localparam logic [ATT_W-1:0] ATTEMPTS_INIT = 3'h5;
  localparam logic [ATT_W-1:0] ATTEMPTS_NONE = 3'h0;

  typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_EVAL} dsle_state_e;

  // Status word, low bits of the status register
  typedef struct packed {
    logic [7:0] lastOpcode;
    logic [ATT_W-1:0] attempts;
    logic erasePrepared;
    logic levelMax;
    logic lockEnabled;
    logic locked;
    logic frozen;
    logic aborted;
    logic done;
    logic busy;
  } dsle_status_s;

  localparam int STAT_W = $bits(dsle_status_s);

endpackage

/* File: test/dsle_host_model.sv */
`timescale 1ns/1ns
module dsle_host_model
  import dsle_pkg::*;
(
  input wire logic mclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [dsle_pkg::APB_DW-1:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [dsle_pkg::APB_AW-1:0] paddr,
  output logic [dsle_pkg::APB_DW-1:0] pwdata
);
  import dsle_pkg::*;
  logic errSeen;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    errSeen = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // One APB transfer, held until pready is sampled high
  task automatic xfer(input logic wr, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d,
      output logic [APB_DW-1:0] q);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    q = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  ////////////////////////////////////////////////////////////////
  // Password block; seeds differ only in the last password word
  task automatic sendBlock(input logic [15:0] ctrl, input logic [7:0] seed, input logic [15:0] rev);
    logic [APB_DW-1:0] q;
    logic [15:0] w;
    for (int i = 0; i < 256; i++) begin
      w = (i == 0) ? ctrl : (i == 17) ? rev : (i == 16) ? {seed, 8'h10} : (i < 16) ? {8'h3C, i[7:0]} : 16'hA5A5;
      xfer(1'b1, OFS_DATA, {16'h0000, w}, q);
    end
  endtask
endmodule // dsle_host_model

/* File: test/dsle_bench.sv */
`timescale 1ns/1ns
module dsle_bench;
  import dsle_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst;
  logic hwResetPin;
  logic psel;
  logic penable;
  logic pwrite;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata;
  logic [APB_DW-1:0] prdata;
  logic pready;
  logic pslverr;
  logic frozenOut;
  logic lockedOut;
  logic eraseStart;
  logic eraseEnhanced;
  logic [APB_DW-1:0] q;
  dsle_status_s st;
  int errTotal = 0;
  int nTests = 0;
  int nErase = 0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (eraseStart === 1'b1) nErase++;
  dsle_core i_dsle_core(.mclk(mclk), .sys_rst(sys_rst), .hwResetPin(hwResetPin), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frozenOut(frozenOut), .lockedOut(lockedOut), .eraseStart(eraseStart), .eraseEnhanced(eraseEnhanced));
  dsle_host_model i_dsle_host_model(.mclk(mclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    nTests++;
    if (got !== exp) begin
      errTotal++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic getStat();
    i_dsle_host_model.xfer(1'b0, OFS_STAT, '0, q);
    st = dsle_status_s'(q[STAT_W-1:0]);
  endtask
  task automatic run(input logic [7:0] op, input logic [15:0] ctrl, input logic [7:0] seed, input logic [15:0] rev);
    int n;
    n = 0;
    i_dsle_host_model.xfer(1'b1, OFS_CMD, {24'h0, op}, q);
    if (op != OP_ERASE_PREP && op != OP_FREEZE) i_dsle_host_model.sendBlock(ctrl, seed, rev);
    do begin
      getStat();
      n++;
    end while (!(st.busy === 1'b0 && st.done === 1'b1) && n < 10);
    chk(st.done, 1'b1, "completion");
  endtask
  task automatic expect3(input logic ab, input logic lk, input logic [2:0] at, input string what);
    chk(st.aborted, ab, {what, " abort"});
    chk(st.locked, lk, {what, " lock"});
    chk(lockedOut, lk, {what, " lock pin"});
    chk(st.attempts, at, {what, " attempts"});
  endtask
  task automatic hwReset();
    @(posedge mclk);
    hwResetPin <= 1'b1;
    repeat (3) @(posedge mclk);
    hwResetPin <= 1'b0;
    repeat (5) @(posedge mclk);
    getStat();
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic tBasic();
    getStat();
    expect3(1'b0, 1'b0, 3'h5, "reset");
    chk(frozenOut, 1'b0, "reset frozen");
    i_dsle_host_model.xfer(1'b0, 8'h10, '0, q);
    chk({q[30:0], i_dsle_host_model.errSeen}, 32'h1, "unmapped");
    run(8'hA0, 16'h0000, 8'h11, 16'h0);
    expect3(1'b1, 1'b0, 3'h5, "unknown op");
    $display("basic done");
  endtask
  task automatic tUserHigh();
    run(OP_SET_PW, 16'h80FE, 8'h11, 16'h0);
    expect3(1'b0, 1'b0, 3'h5, "set user");
    run(OP_SET_PW, 16'h0001, 8'h22, 16'hBEEF);
    chk({st.lockEnabled, st.levelMax}, 2'b10, "set master");
    i_dsle_host_model.xfer(1'b0, OFS_REV, '0, q);
    chk(q[15:0], 16'hBEEF, "revision");
    hwReset();
    chk(lockedOut, 1'b1, "locked");
    run(OP_UNLOCK, 16'h0001, 8'h22, 16'h0);
    expect3(1'b0, 1'b0, 3'h5, "master unlock");
    hwReset();
    run(OP_UNLOCK, 16'h0000, 8'h33, 16'h0);
    expect3(1'b1, 1'b1, 3'h4, "bad unlock");
    run(OP_UNLOCK, 16'h0000, 8'h11, 16'h0);
    expect3(1'b0, 1'b0, 3'h4, "user unlock");
    run(OP_UNLOCK, 16'h0000, 8'h33, 16'h0);
    expect3(1'b1, 1'b0, 3'h4, "unlocked bad");
    run(OP_DISABLE_PW, 16'h0000, 8'h33, 16'h0);
    chk({st.aborted, st.lockEnabled}, 2'b11, "disable bad");
    run(OP_DISABLE_PW, 16'h0000, 8'h11, 16'h0);
    chk({st.aborted, st.lockEnabled}, 2'b00, "disable");
    $display("user high done");
  endtask
  task automatic tMaxLevel();
    run(OP_SET_PW, 16'h0100, 8'h11, 16'h0);
    chk(st.levelMax, 1'b1, "max level");
    hwReset();
    run(OP_UNLOCK, 16'h0001, 8'h22, 16'h0);
    expect3(1'b1, 1'b1, 3'h4, "master at max");
    repeat (4) run(OP_UNLOCK, 16'h0000, 8'h33, 16'h0);
    expect3(1'b1, 1'b1, 3'h0, "run out");
    run(OP_UNLOCK, 16'h0000, 8'h11, 16'h0);
    expect3(1'b1, 1'b1, 3'h0, "good at zero");
    run(OP_ERASE_PREP, 16'h0, 8'h0, 16'h0);
    run(OP_ERASE_UNIT, 16'h0000, 8'h11, 16'h0);
    expect3(1'b1, 1'b1, 3'h0, "erase at zero");
    hwReset();
    chk(st.attempts, 3'h5, "restored");
    run(OP_SET_PW, 16'h0001, 8'h33, 16'h1234);
    expect3(1'b1, 1'b1, 3'h5, "set while locked");
    i_dsle_host_model.xfer(1'b0, OFS_REV, '0, q);
    chk(q[15:0], 16'hBEEF, "revision kept");
    run(OP_ERASE_UNIT, 16'h0000, 8'h11, 16'h0);
    expect3(1'b1, 1'b1, 3'h5, "no prepare");
    run(OP_ERASE_PREP, 16'h0, 8'h0, 16'h0);
    run(OP_ERASE_UNIT, 16'h0000, 8'h33, 16'h0);
    expect3(1'b1, 1'b1, 3'h5, "erase bad");
    run(OP_ERASE_PREP, 16'h0, 8'h0, 16'h0);
    run(OP_ERASE_UNIT, 16'h0002, 8'h11, 16'h0);
    expect3(1'b0, 1'b0, 3'h5, "erase good");
    chk({eraseEnhanced, nErase[7:0]}, 9'h101, "erase pulse");
    run(OP_ERASE_PREP, 16'h0, 8'h0, 16'h0);
    run(OP_ERASE_UNIT, 16'h0000, 8'h11, 16'h0);
    expect3(1'b0, 1'b0, 3'h5, "normal erase");
    chk({eraseEnhanced, nErase[7:0]}, 9'h002, "normal pulse");
    run(OP_SET_PW, 16'h0000, 8'h11, 16'h0);
    hwReset();
    run(OP_UNLOCK, 16'h0001, 8'h22, 16'h0);
    expect3(1'b0, 1'b0, 3'h5, "master back");
    $display("max level done");
  endtask
  task automatic tFreeze();
    logic [7:0] ops [5];
    ops = '{OP_SET_PW, OP_UNLOCK, OP_DISABLE_PW, OP_ERASE_PREP, OP_ERASE_UNIT};
    run(OP_FREEZE, 16'h0, 8'h0, 16'h0);
    chk({st.aborted, frozenOut}, 2'b01, "freeze");
    run(OP_FREEZE, 16'h0, 8'h0, 16'h0);
    chk({st.aborted, st.frozen}, 2'b01, "refreeze");
    foreach (ops[i]) begin
      run(ops[i], 16'h0000, 8'h11, 16'h0);
      chk({st.aborted, st.frozen, st.attempts}, 5'h1D, "frozen cmd");
    end
    hwReset();
    chk({frozenOut, lockedOut}, 2'b01, "thaw");
    run(OP_UNLOCK, 16'h0000, 8'h11, 16'h0);
    expect3(1'b0, 1'b0, 3'h5, "after thaw");
    $display("freeze done");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic wrapUp();
    $display("Checks %0d, mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    errTotal++;
    $display("BAD %0t watchdog expired", $time);
    wrapUp();
  end
  initial begin
    sys_rst = 1'b1;
    hwResetPin = 1'b0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    tBasic();
    tUserHigh();
    tMaxLevel();
    tFreeze();
    wrapUp();
  end
endmodule // dsle_bench
